// [verilog/arf_defines.svh]
`ifndef ARF_DEFINES_SVH
`define ARF_DEFINES_SVH
// prefix layout and broadcast
`define ARF_ADDR_W 16
`define ARF_BCAST_ADDR 16'hffff
`define ARF_MAX_LEN 8'hf0
// discrete input map, as seen by a read-discrete-input request
`define ARF_DI_ADDR 16'd20001
`define ARF_DI_SLAVE 8'h01
`define ARF_FC_READ_DI 8'h02
`define ARF_CRC_LO 8'hb9
`define ARF_CRC_HI 8'hca
// timing: milliseconds at 100 MHz
`define ARF_CLK_MHZ 100
`define ARF_CYC_PER_MS (`ARF_CLK_MHZ * 1000)
`define ARF_MS_W 16
`define ARF_WAKE_CODE 8'h55
`define ARF_WAKE_LEN 8'h04
`endif

// [verilog/arf_pkg.sv]
`include "arf_defines.svh"
package arf_pkg;
  typedef struct packed
  {
    logic valid;
    logic [7:0] data;
    logic last;
  } arf_byte_s;
  typedef struct packed
  {
    logic [15:0] addr;
    logic [7:0] chan;
  } arf_dest_s;
  typedef struct packed
  {
    logic [15:0] wake_ms;
    logic [15:0] prewake_ms;
    logic [15:0] resp_ms;
  } arf_timing_s;
endpackage

// [verilog/arf_framer.sv]
// Function
// - in fixed mode, first two bytes are destination address
// - in fixed mode, third byte is channel, payload follows
// - any address and channel accepted
// - dry contact input readable at 20001
// - answers read-discrete-input to slave one, in configuration mode only
// - low power needs both ends enabled
// - master prepends wake code in low power
// - wake period shared by master and slave; master sends a fixed 4-byte wake code instead
// - sensor supply raised early by pre-wake time
// - serial receiver open for response timeout
// - slave delays output by wake plus pre-wake
// - late sensor replies are not forwarded
// - address all ones receives every frame
// - bytes beyond max length are dropped
`timescale 1ns/1ns
`default_nettype none
`include "arf_defines.svh"
module arf_framer
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic fixed_mode,
  input wire logic sleep_mode_enable,
  input wire logic master_role,
  input wire logic config_mode,
  input wire logic [15:0] own_addr,
  input wire arf_pkg::arf_timing_s timing,
  input wire logic dry_contact_input,
  input wire arf_pkg::arf_byte_s ser_in,
  output arf_pkg::arf_dest_s tx_dest,
  output arf_pkg::arf_byte_s tx_out,
  input wire arf_pkg::arf_byte_s rf_in,
  input wire logic [15:0] rf_dest_addr,
  output arf_pkg::arf_byte_s ser_out,
  output logic sensor_supply_output,
  output logic ser_rx_open,
  output logic standby
);
  import arf_pkg::*;

  function automatic logic [31:0] ms_cycles(input logic [15:0] ms);
    ms_cycles = 32'(ms) * 32'(`ARF_CYC_PER_MS);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // input synchroniser for the dry contact, a mechanical pin
  logic di_s1_reg, di_s2_reg;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      di_s1_reg <= 1'b0;
      di_s2_reg <= 1'b0;
    end
    else
    begin
      di_s1_reg <= dry_contact_input;
      di_s2_reg <= di_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial-to-radio framer
  typedef enum logic [4:0]
  {
    TX_ADDR_HI = 5'b00001,
    TX_ADDR_LO = 5'b00010,
    TX_CHAN = 5'b00100,
    TX_WAKE = 5'b01000,
    TX_DATA = 5'b10000
  } arf_tx_e;
  arf_tx_e tx_st_reg, tx_st_next;
  arf_dest_s dest_reg, dest_next;
  arf_byte_s tx_reg, tx_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] mb_idx_reg, mb_idx_next;
  logic mb_ok_reg, mb_ok_next;
  logic [7:0] wk_reg, wk_next;
  logic held_reg, held_next;
  logic [7:0] held_data_reg, held_data_next;
  logic held_last_reg, held_last_next;

  // expected read-discrete-input request bytes
  function automatic logic [7:0] mb_req(input logic [7:0] i);
    case (i)
      8'h00: mb_req = `ARF_DI_SLAVE;
      8'h01: mb_req = `ARF_FC_READ_DI;
      8'h05: mb_req = 8'h01;
      8'h06: mb_req = `ARF_CRC_LO;
      8'h07: mb_req = `ARF_CRC_HI;
      default: mb_req = 8'h00;
    endcase
  endfunction

  logic tx_lp;
  assign tx_lp = sleep_mode_enable && master_role;

  // a sleeping slave takes serial data only while its reply window is open
  logic open_reg, open_next;
  logic sin_valid;
  assign sin_valid = ser_in.valid && (!sleep_mode_enable || master_role || open_reg);

  always_comb
  begin
    tx_st_next = tx_st_reg;
    dest_next = dest_reg;
    tx_next = '0;
    cnt_next = cnt_reg;
    mb_idx_next = mb_idx_reg;
    mb_ok_next = mb_ok_reg;
    wk_next = wk_reg;
    held_next = held_reg;
    held_data_next = held_data_reg;
    held_last_next = held_last_reg;
    if (config_mode)
    begin
      // radio is asleep in configuration mode; only request matching runs
      tx_st_next = TX_ADDR_HI;
      if (ser_in.valid)
      begin
        mb_ok_next = (mb_idx_reg == 8'h00 ? 1'b1 : mb_ok_reg)
          && (ser_in.data == mb_req(mb_idx_reg));
        mb_idx_next = ser_in.last ? 8'h00 : mb_idx_reg + 8'h01;
      end
    end
    else
    begin
      case (tx_st_reg)
        TX_ADDR_HI:
        begin
          cnt_next = 8'h00;
          if (sin_valid && fixed_mode)
          begin
            dest_next.addr[15:8] = ser_in.data;
            tx_st_next = TX_ADDR_LO;
          end
          else if (sin_valid)
          begin
            held_next = 1'b1;
            held_data_next = ser_in.data;
            held_last_next = ser_in.last;
            dest_next = '{addr: own_addr, chan: dest_reg.chan};
            tx_st_next = tx_lp ? TX_WAKE : TX_DATA;
            wk_next = 8'h00;
          end
        end
        TX_ADDR_LO:
          if (sin_valid)
          begin
            dest_next.addr[7:0] = ser_in.data;
            tx_st_next = TX_CHAN;
          end
        TX_CHAN:
          if (sin_valid)
          begin
            dest_next.chan = ser_in.data;
            wk_next = 8'h00;
            tx_st_next = tx_lp ? TX_WAKE : TX_DATA;
          end
        TX_WAKE:
        begin
          // wake preamble ahead of the payload; the first payload byte arriving now is held
          tx_next = '{valid: 1'b1, data: `ARF_WAKE_CODE, last: 1'b0};
          wk_next = wk_reg + 8'h01;
          if (wk_reg == `ARF_WAKE_LEN - 8'h01)
            tx_st_next = TX_DATA;
        end
        TX_DATA:
        begin
          if (held_reg)
          begin
            // a byte landing while the held one drains takes its place
            held_next = sin_valid && !held_last_reg;
            held_data_next = ser_in.data;
            held_last_next = ser_in.last;
            if (cnt_reg < `ARF_MAX_LEN)
            begin
              tx_next = '{valid: 1'b1, data: held_data_reg,
                last: held_last_reg || (cnt_reg == `ARF_MAX_LEN - 8'h01)};
              cnt_next = cnt_reg + 8'h01;
            end
            if (held_last_reg)
              tx_st_next = TX_ADDR_HI;
          end
          else if (sin_valid)
          begin
            // bytes past the packet limit are discarded
            if (cnt_reg < `ARF_MAX_LEN)
            begin
              tx_next = '{valid: 1'b1, data: ser_in.data,
                last: ser_in.last || (cnt_reg == `ARF_MAX_LEN - 8'h01)};
              cnt_next = cnt_reg + 8'h01;
            end
            if (ser_in.last)
              tx_st_next = TX_ADDR_HI;
          end
        end
        default: tx_st_next = TX_ADDR_HI;
      endcase
      // only one byte can be held, so the host must pause one byte per wake byte
      if (tx_st_reg == TX_WAKE && ser_in.valid && !held_reg)
      begin
        held_next = 1'b1;
        held_data_next = ser_in.data;
        held_last_next = ser_in.last;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_st_reg <= TX_ADDR_HI;
      dest_reg <= '0;
      tx_reg <= '0;
      cnt_reg <= 8'h00;
      mb_idx_reg <= 8'h00;
      mb_ok_reg <= 1'b0;
      wk_reg <= 8'h00;
      held_reg <= 1'b0;
      held_data_reg <= 8'h00;
      held_last_reg <= 1'b0;
    end
    else
    begin
      tx_st_reg <= tx_st_next;
      dest_reg <= dest_next;
      tx_reg <= tx_next;
      cnt_reg <= cnt_next;
      mb_idx_reg <= mb_idx_next;
      mb_ok_reg <= mb_ok_next;
      wk_reg <= wk_next;
      held_reg <= held_next;
      held_data_reg <= held_data_next;
      held_last_reg <= held_last_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // radio-to-serial path with low-power slave schedule
  typedef enum logic [4:0]
  {
    RX_IDLE = 5'b00001,
    RX_DELAY = 5'b00010,
    RX_OUT = 5'b00100,
    RX_LISTEN = 5'b01000,
    RX_ANSWER = 5'b10000
  } arf_rx_e;
  arf_rx_e rx_st_reg, rx_st_next;
  logic [31:0] tmr_reg, tmr_next;
  logic [7:0] rbuf [0:255];
  logic [7:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [7:0] ans_idx_reg, ans_idx_next;
  arf_byte_s so_reg, so_next;
  logic sup_reg, sup_next;
  logic sb_reg, sb_next;
  logic rx_lp, rx_hit, mb_done, di_hit;

  assign rx_lp = sleep_mode_enable && !master_role;
  assign rx_hit = rf_in.valid && (rf_dest_addr == own_addr
    || own_addr == `ARF_BCAST_ADDR || rf_dest_addr == `ARF_BCAST_ADDR);
  assign mb_done = config_mode && ser_in.valid && ser_in.last && mb_idx_reg == 8'h07
    && mb_ok_reg && ser_in.data == mb_req(8'h07);
  // data address 20001 is offset zero of the discrete inputs
  assign di_hit = (`ARF_DI_ADDR - 16'd20001) == 16'h0000;

  always_ff @(posedge mclk)
  begin
    if (rx_hit && rx_st_reg != RX_ANSWER)
      rbuf[wr_reg] <= rf_in.data;
  end

  always_comb
  begin
    rx_st_next = rx_st_reg;
    tmr_next = tmr_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    ans_idx_next = ans_idx_reg;
    so_next = '0;
    sup_next = sup_reg;
    open_next = open_reg;
    sb_next = sb_reg;
    if (rx_hit && rx_st_reg != RX_ANSWER)
      wr_next = wr_reg + 8'h01;
    case (rx_st_reg)
      RX_IDLE:
      begin
        sb_next = rx_lp;
        if (mb_done && di_hit)
        begin
          ans_idx_next = 8'h00;
          rx_st_next = RX_ANSWER;
        end
        else if (rx_hit && rx_lp)
        begin
          // hold data for wake period plus pre-wake before emitting it
          tmr_next = ms_cycles(timing.wake_ms) + ms_cycles(timing.prewake_ms);
          sb_next = 1'b0;
          rx_st_next = RX_DELAY;
        end
        else if (rx_hit)
          rx_st_next = RX_OUT;
      end
      RX_DELAY:
      begin
        // supply comes up once only the pre-wake time remains
        if (tmr_reg <= ms_cycles(timing.prewake_ms))
          sup_next = 1'b1;
        if (tmr_reg == 32'h0)
          rx_st_next = RX_OUT;
        else
          tmr_next = tmr_reg - 32'h1;
      end
      RX_OUT:
        if (rd_reg != wr_reg)
        begin
          so_next = '{valid: 1'b1, data: rbuf[rd_reg], last: rd_reg + 8'h01 == wr_reg};
          rd_next = rd_reg + 8'h01;
        end
        else if (rx_lp)
        begin
          tmr_next = ms_cycles(timing.resp_ms);
          open_next = 1'b1;
          rx_st_next = RX_LISTEN;
        end
        else
          rx_st_next = RX_IDLE;
      RX_LISTEN:
      begin
        // reply forwarding happens in the framer; late replies are shut out
        if (tmr_reg == 32'h0 || (ser_in.valid && ser_in.last))
        begin
          open_next = 1'b0;
          sup_next = 1'b0;
          sb_next = 1'b1;
          rx_st_next = RX_IDLE;
        end
        else
          tmr_next = tmr_reg - 32'h1;
      end
      RX_ANSWER:
      begin
        // reply: slave, function, count, state; crc left to the serial layer
        case (ans_idx_reg)
          8'h00: so_next = '{valid: 1'b1, data: `ARF_DI_SLAVE, last: 1'b0};
          8'h01: so_next = '{valid: 1'b1, data: `ARF_FC_READ_DI, last: 1'b0};
          8'h02: so_next = '{valid: 1'b1, data: 8'h01, last: 1'b0};
          default: so_next = '{valid: 1'b1, data: {7'h00, di_s2_reg}, last: 1'b1};
        endcase
        ans_idx_next = ans_idx_reg + 8'h01;
        if (ans_idx_reg == 8'h03)
          rx_st_next = RX_IDLE;
      end
      default: rx_st_next = RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_st_reg <= RX_IDLE;
      tmr_reg <= 32'h0;
      wr_reg <= 8'h00;
      rd_reg <= 8'h00;
      ans_idx_reg <= 8'h00;
      so_reg <= '0;
      sup_reg <= 1'b0;
      open_reg <= 1'b0;
      sb_reg <= 1'b0;
    end
    else
    begin
      rx_st_reg <= rx_st_next;
      tmr_reg <= tmr_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      ans_idx_reg <= ans_idx_next;
      so_reg <= so_next;
      sup_reg <= sup_next;
      open_reg <= open_next;
      sb_reg <= sb_next;
    end
  end

  assign tx_dest = dest_reg;
  assign tx_out = tx_reg;
  assign ser_out = so_reg;
  assign sensor_supply_output = sup_reg;
  assign ser_rx_open = open_reg;
  assign standby = sb_reg;
endmodule
`default_nettype wire

// [verif/arf_framer_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
`include "arf_defines.svh"
module arf_framer_monitor
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic fixed_mode,
  input wire logic sleep_mode_enable,
  input wire logic master_role,
  input wire logic config_mode,
  input wire logic [15:0] own_addr,
  input wire arf_pkg::arf_timing_s timing,
  input wire logic dry_contact_input,
  input wire arf_pkg::arf_byte_s ser_in,
  input wire arf_pkg::arf_byte_s tx_out,
  input wire arf_pkg::arf_byte_s rf_in,
  input wire logic [15:0] rf_dest_addr,
  input wire arf_pkg::arf_byte_s ser_out,
  input wire logic sensor_supply_output,
  input wire logic ser_rx_open,
  input wire logic standby
);
  import arf_pkg::*;
  logic [7:0] idx_reg;
  logic [47:0] cnt_reg;
  logic arm_reg;
  logic new_reg;
  wire logic take = ser_in.valid && !config_mode;
  wire logic fx = take && fixed_mode && !sleep_mode_enable;
  wire logic hit = rf_in.valid && (rf_dest_addr == own_addr || &rf_dest_addr || &own_addr);
  // one block to save space; cnt only means something while arm_reg is set
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      idx_reg <= 8'h00;
      cnt_reg <= 48'h0;
      arm_reg <= 1'b0;
      new_reg <= 1'b1;
    end
    else
    begin
      idx_reg <= !take ? idx_reg : ser_in.last ? 8'h00 : idx_reg + {7'h00, idx_reg != 8'hff};
      cnt_reg <= (hit && !arm_reg) ? 48'h0 : cnt_reg + 48'h1;
      arm_reg <= !ser_out.valid && (arm_reg || (hit && sleep_mode_enable && !master_role));
      new_reg <= tx_out.valid ? tx_out.last : new_reg;
    end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  prefix_strip_a: assert property
    (fx && idx_reg < 8'h03 |=> !tx_out.valid) else $error("prefix sent");
  payload_pass_a: assert property
    (fx && idx_reg > 8'h02 && idx_reg < 8'hf3
      |=> tx_out.valid && tx_out.data == $past(ser_in.data)) else $error("payload lost");
  length_cap_a: assert property
    (fx && idx_reg > 8'hf2 |=> !tx_out.valid) else $error("over length sent");
  wake_first_a: assert property
    (master_role && sleep_mode_enable && tx_out.valid && new_reg
      |-> tx_out.data == `ARF_WAKE_CODE) else $error("no wake code");
  rx_deliver_a: assert property
    (!sleep_mode_enable && !config_mode && hit |-> ##[1:4] ser_out.valid)
    else $error("not delivered");
  sleep_delay_a: assert property
    (arm_reg && ser_out.valid
      |-> cnt_reg >= (48'(timing.wake_ms) + 48'(timing.prewake_ms)) * 48'd100000)
    else $error("output early");
  supply_off_a: assert property
    ($fell(ser_rx_open) |-> ##[0:3] !sensor_supply_output && standby) else $error("supply on");
  di_answer_a: assert property
    (config_mode && ser_in.valid && ser_in.last && ser_in.data == `ARF_CRC_HI
      |-> ##5 ser_out.valid && ser_out.last && ser_out.data == {7'h00, dry_contact_input})
    else $error("no input answer");
  cover property (arm_reg && ser_out.valid);
  cover property (fx && idx_reg == 8'hf2);
  cover property (config_mode && ser_out.valid && ser_out.last);
endmodule
bind arf_framer arf_framer_monitor u_mon
(
  .mclk(mclk), .rst(rst), .fixed_mode(fixed_mode), .sleep_mode_enable(sleep_mode_enable),
  .master_role(master_role), .config_mode(config_mode), .own_addr(own_addr),
  .timing(timing), .dry_contact_input(dry_contact_input), .ser_in(ser_in),
  .tx_out(tx_out), .rf_in(rf_in), .rf_dest_addr(rf_dest_addr), .ser_out(ser_out),
  .sensor_supply_output(sensor_supply_output), .ser_rx_open(ser_rx_open), .standby(standby)
);
`default_nettype wire

// [verif/arf_peer_model.sv]
`timescale 1ns/1ns
`default_nettype none
module arf_peer_model
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic loop_en,
  input wire logic [1:0] lag,
  input wire arf_pkg::arf_byte_s tx_out,
  input wire arf_pkg::arf_dest_s tx_dest,
  input wire arf_pkg::arf_byte_s inject,
  input wire logic [15:0] inject_addr,
  output arf_pkg::arf_byte_s rf_in,
  output logic [15:0] rf_dest_addr
);
  import arf_pkg::*;
  arf_byte_s air_reg [4];
  logic [15:0] dst_reg [4];
  // a peer node relays what it heard unchanged, lag plus one cycles later
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      air_reg <= '{default: '0};
      dst_reg <= '{default: 16'h0};
    end
    else
    begin
      air_reg[0] <= loop_en ? tx_out : inject;
      dst_reg[0] <= loop_en ? tx_dest.addr : inject_addr;
      for (int i = 1; i < 4; i++)
      begin
        air_reg[i] <= air_reg[i - 1];
        dst_reg[i] <= dst_reg[i - 1];
      end
    end
  // idle air must not look like the last byte, so show its inverse
  always_comb
  begin
    rf_in = air_reg[lag];
    rf_in.data = rf_in.valid ? rf_in.data : ~rf_in.data;
    rf_dest_addr = rf_in.valid ? dst_reg[lag] : ~dst_reg[lag];
  end
endmodule
`default_nettype wire

// [verif/arf_framer_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module arf_framer_bench;
  import arf_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic fixed_mode = 1'b1;
  logic sleep_mode_enable = 1'b0;
  logic master_role = 1'b1;
  logic config_mode = 1'b0;
  logic dry_contact_input = 1'b1;
  logic loop_en = 1'b0;
  logic [1:0] lag = 2'h0;
  logic [15:0] own_addr = 16'h0003;
  logic [15:0] inject_addr = 16'h0003;
  arf_timing_s timing = '{16'h0000, 16'h0001, 16'h0001};
  arf_byte_s ser_in = '0;
  arf_byte_s inject = '0;
  arf_dest_s tx_dest;
  arf_byte_s tx_out, rf_in, ser_out;
  logic [15:0] rf_dest_addr;
  logic sensor_supply_output, ser_rx_open, standby;
  logic [7:0] txq [$];
  logic [7:0] sxq [$];
  logic [7:0] big [$];
  logic [23:0] dst [3] = '{24'h000505, 24'hffffff, 24'h8000a7};
  int errors = 0;
  int n_checks = 0;
  always #5 mclk = ~mclk;
  arf_framer DUT
  (
    .mclk(mclk), .rst(rst), .fixed_mode(fixed_mode), .sleep_mode_enable(sleep_mode_enable),
    .master_role(master_role), .config_mode(config_mode), .own_addr(own_addr),
    .timing(timing), .dry_contact_input(dry_contact_input), .ser_in(ser_in),
    .tx_dest(tx_dest), .tx_out(tx_out), .rf_in(rf_in), .rf_dest_addr(rf_dest_addr),
    .ser_out(ser_out), .sensor_supply_output(sensor_supply_output),
    .ser_rx_open(ser_rx_open), .standby(standby)
  );
  arf_peer_model peer
  (
    .mclk(mclk), .rst(rst), .loop_en(loop_en), .lag(lag), .tx_out(tx_out), .tx_dest(tx_dest),
    .inject(inject), .inject_addr(inject_addr), .rf_in(rf_in), .rf_dest_addr(rf_dest_addr)
  );
  always @(posedge mclk)
  begin
    if (tx_out.valid === 1'b1)
      txq.push_back(tx_out.data);
    if (ser_out.valid === 1'b1)
      sxq.push_back(ser_out.data);
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic l);
    @(posedge mclk);
    ser_in <= '{1'b1, d, l};
  endtask
  task automatic idle(input int n);
    @(posedge mclk);
    ser_in <= '{1'b0, ~ser_in.data, 1'b0};
    repeat (n) @(posedge mclk);
  endtask
  task automatic frame(input logic [7:0] b [$]);
    foreach (b[i])
      send(b[i], i == b.size() - 1);
    idle(2);
  endtask
  task automatic wait_q(input int ntx, input int nsx, input int lim);
    repeat (lim)
      if (txq.size() < ntx || sxq.size() < nsx)
        @(posedge mclk);
  endtask
  task automatic over_air(input logic [15:0] a, input logic [1:0] l, input int n);
    sxq.delete();
    lag <= l;
    frame('{a[15:8], a[7:0], 8'h05, 8'h66});
    wait_q(0, n, 30);
    idle(4);
    chk({8'(sxq.size()), n > 0 ? sxq[0] : 8'h66}, {8'(n), 8'h66});
  endtask
  task automatic conclude;
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #1500000;
    errors++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    foreach (dst[i])
    begin
      txq.delete();
      frame('{dst[i][23:16], dst[i][15:8], dst[i][7:0], 8'h41, 8'h42, 8'h43});
      wait_q(3, 0, 20);
      chk(tx_dest, dst[i]);
      chk({8'(txq.size()), txq[0], txq[1], txq[2]}, 32'h03414243);
    end
    txq.delete();
    big = '{8'h00, 8'h05, 8'h05};
    repeat (245)
      big.push_back(8'(big.size()));
    frame(big);
    wait_q(240, 0, 20);
    chk(txq.size(), 240);
    loop_en <= 1'b1;
    over_air(16'hffff, 2'h3, 1);
    over_air(16'h0003, 2'h0, 1);
    over_air(16'h0009, 2'h1, 0);
    own_addr <= 16'hffff;
    over_air(16'h0009, 2'h2, 1);
    loop_en <= 1'b0;
    sleep_mode_enable <= 1'b1;
    txq.delete();
    big = '{8'h00, 8'h05, 8'h05, 8'h41};
    foreach (big[i])
      send(big[i], 1'b0);
    idle(8);
    frame('{8'h42});
    wait_q(6, 0, 30);
    chk({txq[0], txq[1], txq[2], txq[3]}, 32'h55555555);
    chk({txq[4], txq[5]}, 16'h4142);
    sleep_mode_enable <= 1'b0;
    config_mode <= 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      dry_contact_input <= v[0];
      idle(4);
      sxq.delete();
      frame('{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'hb9, 8'hca});
      wait_q(0, 4, 20);
      chk({sxq[0], sxq[1], sxq[2], sxq[3]}, {24'h010201, 7'h00, v[0]});
    end
    sxq.delete();
    frame('{8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'hb9, 8'h0a});
    idle(8);
    chk(sxq.size(), 0);
    config_mode <= 1'b0;
    fixed_mode <= 1'b0;
    master_role <= 1'b0;
    sleep_mode_enable <= 1'b1;
    own_addr <= 16'h0003;
    idle(2);
    txq.delete();
    sxq.delete();
    inject <= '{1'b1, 8'h3c, 1'b1};
    @(posedge mclk);
    inject <= '{1'b0, 8'hc3, 1'b0};
    repeat (20) @(posedge mclk);
    chk(sensor_supply_output, 1'b1);
    repeat (50000) @(posedge mclk);
    chk(sxq.size(), 0);
    wait_q(0, 1, 60000);
    repeat (3) @(posedge mclk);
    chk({sxq[0], ser_rx_open}, 9'h079);
    send(8'h7e, 1'b1);
    idle(6);
    chk({txq[0], sensor_supply_output, standby}, 10'h1f9);
    txq.delete();
    frame('{8'h11});
    idle(6);
    chk(txq.size(), 0);
    conclude();
  end
endmodule
`default_nettype wire
